// [msrd_pkg.sv]
// Constants and types of the motion sequence record decoder
package msrd_pkg;
  // Register word indexes on the bus
  localparam logic [3:0] OFS_CTRL      = 4'h0;
  localparam logic [3:0] OFS_STATUS    = 4'h1;
  localparam logic [3:0] OFS_REC_INDEX = 4'h2;
  localparam logic [3:0] OFS_REC_W0    = 4'h3;
  localparam logic [3:0] OFS_REC_W1    = 4'h4;
  localparam logic [3:0] OFS_REC_W2    = 4'h5;
  localparam logic [3:0] OFS_REC_W3    = 4'h6;
  localparam logic [3:0] OFS_REC_CMD   = 4'h7;
  localparam logic [3:0] OFS_COND_IDX  = 4'h8;
  localparam logic [3:0] OFS_COND_DATA = 4'h9;
  localparam logic [3:0] OFS_TAG       = 4'hA;
  // Control and status bit positions
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_ABORT_BIT = 1;
  localparam int CTRL_SEQ_POS   = 16;
  localparam int TAG_RESET_BIT  = 0;
  localparam int TAG_ERRCLR_BIT = 1;
  localparam int REC_COMMIT_BIT = 0;
  localparam int STAT_SEQ_POS   = 4;
  localparam int STAT_STATE_POS = 16;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  // Record command codes
  localparam logic [15:0] CMD_NONE  = 16'h0000;
  localparam logic [15:0] CMD_JUMP  = 16'h0001;
  localparam logic [15:0] CMD_FOR   = 16'h0002;
  localparam logic [15:0] CMD_NEXT  = 16'h0003;
  localparam logic [15:0] CMD_PSET  = 16'h0004;
  localparam logic [15:0] CMD_PRSET = 16'h0005;
  localparam logic [15:0] CMD_END   = 16'h004F;
  localparam logic [7:0]  CMD_MOTION_HI = 8'h08;
  // Field limits
  localparam logic [6:0] COND_MAX   = 7'h64;
  localparam logic [8:0] DEST_MAX   = 9'h1F4;
  localparam logic [5:0] LOOP_MAX   = 6'h31;
  localparam logic [2:0] END_MAX    = 3'h4;
  localparam logic [9:0] DWELL_MAX  = 10'h3E8;
  localparam logic [9:0] TAG_MAX    = 10'h3E7;
  localparam logic [9:0] TAG_NOWAIT = 10'h1F4;
  localparam logic [7:0] OUT_FWD    = 8'h03;
  localparam logic [7:0] OUT_REV    = 8'h04;
  localparam logic [7:0] OUT_AX_MAX = 8'h04;
  localparam logic [2:0] END_AUTO   = 3'h1;
  localparam int SEQ_DEPTH  = 500;
  localparam int COND_DEPTH = 100;
  localparam int LOOP_DEPTH = 50;
  // Dwell unit timing
  localparam int CLK_HZ        = 100_000_000;
  localparam int DWELL_UNIT_MS = 10;
  localparam int DWELL_TICK_CYCLES = CLK_HZ / 1000 * DWELL_UNIT_MS;
  typedef struct packed {
    logic [15:0] cmd;
    logic [6:0]  jcond;
    logic [8:0]  jdest;
    logic [5:0]  loopno;
    logic [15:0] outsig;
    logic [6:0]  scond;
    logic [6:0]  kcond;
    logic [2:0]  endpat;
    logic [9:0]  dwell;
    logic        mon;
    logic [9:0]  tag;
    logic [3:0]  axes;
    logic [3:0]  zaxis;
  } msrd_rec_t;
  typedef enum logic [3:0] {
    ST_IDLE   = 4'h0,
    ST_FETCH  = 4'h1,
    ST_CHECK  = 4'h3,
    ST_WSTART = 4'h2,
    ST_RUN    = 4'h6,
    ST_INPOS  = 4'h7,
    ST_DWELL  = 4'h5,
    ST_TAG    = 4'h4,
    ST_TWAIT  = 4'hC,
    ST_ADV    = 4'hD,
    ST_FAULT  = 4'hF
  } msrd_state_t;
endpackage

// [msrd_top.sv]
// Motion sequence record decoder and executor with Avalon-MM register slave
//
// Chosen here: the Avalon-MM slave port and the address map.
module msrd_top #(
  parameter int SEQ_DEPTH   = msrd_pkg::SEQ_DEPTH,
  parameter int COND_DEPTH  = msrd_pkg::COND_DEPTH,
  parameter int TICK_CYCLES = msrd_pkg::DWELL_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // Avalon-MM slave
  input  wire logic [3:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  // Condition sense inputs
  input  wire logic [15:0] i_sense,
  // Axis drives
  input  wire logic [3:0]  i_axis_busy,
  input  wire logic [3:0]  i_axis_inpos,
  output logic      [3:0]  o_axis_start,
  output logic      [3:0]  o_axis_stop,
  output logic      [3:0]  o_force_fwd,
  output logic      [3:0]  o_force_rev,
  output logic      [3:0]  o_helical_z,
  output logic      [2:0]  o_end_pattern,
  // Completion tag and status
  output logic      [9:0]  o_tag_code,
  output logic             o_tag_valid,
  output logic             o_running,
  output logic             o_error
);

  msrd_pkg::msrd_rec_t   seq_mem [SEQ_DEPTH];
  logic [31:0]           cond_mem [COND_DEPTH];
  logic [8:0]            loop_seq [msrd_pkg::LOOP_DEPTH];
  logic [6:0]            loop_cond [msrd_pkg::LOOP_DEPTH];
  logic [msrd_pkg::LOOP_DEPTH-1:0] loop_valid;
  logic [31:0]           stage_reg [4];
  logic [8:0]            rec_index_reg;
  logic [6:0]            cond_index_reg;
  logic [8:0]            start_seq_reg;
  logic                  host_start_reg;
  logic                  host_abort_reg;
  logic                  host_trst_reg;
  logic                  host_errclr_reg;
  msrd_pkg::msrd_state_t state_reg;
  msrd_pkg::msrd_rec_t   cur_reg;
  logic [8:0]            seq_reg;
  logic [8:0]            base_seq_reg;
  logic                  run_first_reg;
  logic [9:0]            dwell_left_reg;
  logic [31:0]           tick_reg;
  logic                  bus_req;
  logic                  bus_take;

  // Condition record: mask in low half, match value in high half
  function automatic logic cond_met(input logic [6:0] idx);
    logic [31:0] c;
    c = 32'h0000_0000;
    if (idx == 7'h00) begin
      return 1'b1;
    end
    c = cond_mem[int'(idx) - 1];
    return (i_sense & c[15:0]) == c[31:16];
  endfunction

  function automatic logic cond_ok(input logic [6:0] idx);
    return idx <= msrd_pkg::COND_MAX;
  endfunction

  function automatic logic out_ok(input logic [15:0] v);
    logic ax;
    logic lo;
    ax = (v[15:8] != 8'h00) && (v[15:8] <= msrd_pkg::OUT_AX_MAX);
    lo = (v[7:0] == msrd_pkg::OUT_FWD) || (v[7:0] == msrd_pkg::OUT_REV);
    return (v == 16'h0000) || (ax && lo);
  endfunction

  function automatic logic rec_ok(input msrd_pkg::msrd_rec_t r);
    logic ok;
    ok = cond_ok(r.jcond) && cond_ok(r.scond) && cond_ok(r.kcond);
    ok = ok && (r.loopno <= msrd_pkg::LOOP_MAX) && out_ok(r.outsig);
    ok = ok && (r.endpat <= msrd_pkg::END_MAX) && (r.dwell <= msrd_pkg::DWELL_MAX);
    ok = ok && (r.tag <= msrd_pkg::TAG_MAX);
    ok = ok && (r.zaxis == 4'h0 || r.zaxis == 4'h1 || r.zaxis == 4'h2 ||
                r.zaxis == 4'h4 || r.zaxis == 4'h8);
    if (r.cmd == msrd_pkg::CMD_JUMP) begin
      ok = ok && (r.jdest != 9'h000) && (r.jdest <= msrd_pkg::DEST_MAX);
    end
    return ok;
  endfunction

  function automatic msrd_pkg::msrd_rec_t unpack(input logic [31:0] w0,
                                                 input logic [31:0] w1,
                                                 input logic [31:0] w2,
                                                 input logic [31:0] w3);
    msrd_pkg::msrd_rec_t r;
    r = '0;
    r.cmd    = w0[15:0];
    r.jcond  = w0[22:16];
    r.jdest  = w0[31:23];
    r.outsig = w1[15:0];
    r.scond  = w1[22:16];
    r.kcond  = w1[29:23];
    r.endpat = w2[2:0];
    r.dwell  = w2[12:3];
    r.mon    = w2[13];
    r.tag    = w2[23:14];
    r.axes   = w2[27:24];
    r.zaxis  = w2[31:28];
    r.loopno = w3[5:0];
    return r;
  endfunction

  assign bus_req  = i_avs_read | i_avs_write;
  assign bus_take = bus_req & ~o_avs_waitrequest;

  // Bus handshake: one wait cycle, then the access completes
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_avs_waitrequest <= 1'b1;
    end else if (bus_take) begin
      o_avs_waitrequest <= 1'b1;
    end else if (bus_req) begin
      o_avs_waitrequest <= 1'b0;
    end
  end

  // Read data, captured one cycle before completion
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_avs_readdata <= msrd_pkg::WORD_RESET;
    end else if (i_avs_read && o_avs_waitrequest) begin
      case (i_avs_address)
        msrd_pkg::OFS_CTRL: begin
          o_avs_readdata <= {7'h00, start_seq_reg, 16'h0000};
        end
        msrd_pkg::OFS_STATUS: begin
          o_avs_readdata <= {12'h000, state_reg, 3'h0, seq_reg,
                             1'b0, o_tag_valid, o_error, o_running};
        end
        msrd_pkg::OFS_REC_INDEX: o_avs_readdata <= {23'h000000, rec_index_reg};
        msrd_pkg::OFS_REC_W0:    o_avs_readdata <= stage_reg[0];
        msrd_pkg::OFS_REC_W1:    o_avs_readdata <= stage_reg[1];
        msrd_pkg::OFS_REC_W2:    o_avs_readdata <= stage_reg[2];
        msrd_pkg::OFS_REC_W3:    o_avs_readdata <= stage_reg[3];
        msrd_pkg::OFS_COND_IDX:  o_avs_readdata <= {25'h0000000, cond_index_reg};
        msrd_pkg::OFS_COND_DATA: begin
          if (cond_index_reg != 7'h00 && int'(cond_index_reg) <= COND_DEPTH) begin
            o_avs_readdata <= cond_mem[int'(cond_index_reg) - 1];
          end else begin
            o_avs_readdata <= msrd_pkg::WORD_RESET;
          end
        end
        msrd_pkg::OFS_TAG:       o_avs_readdata <= {22'h000000, o_tag_code};
        default:                 o_avs_readdata <= msrd_pkg::WORD_RESET;
      endcase
    end
  end

  // Register writes and one-cycle host command pulses
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rec_index_reg   <= 9'h000;
      cond_index_reg  <= 7'h00;
      start_seq_reg   <= 9'h001;
      host_start_reg  <= 1'b0;
      host_abort_reg  <= 1'b0;
      host_trst_reg   <= 1'b0;
      host_errclr_reg <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        stage_reg[i] <= msrd_pkg::WORD_RESET;
      end
    end else begin
      host_start_reg  <= 1'b0;
      host_abort_reg  <= 1'b0;
      host_trst_reg   <= 1'b0;
      host_errclr_reg <= 1'b0;
      if (bus_take && i_avs_write) begin
        case (i_avs_address)
          msrd_pkg::OFS_CTRL: begin
            start_seq_reg  <= i_avs_writedata[msrd_pkg::CTRL_SEQ_POS +: 9];
            host_start_reg <= i_avs_writedata[msrd_pkg::CTRL_START_BIT];
            host_abort_reg <= i_avs_writedata[msrd_pkg::CTRL_ABORT_BIT];
          end
          msrd_pkg::OFS_REC_INDEX: rec_index_reg  <= i_avs_writedata[8:0];
          msrd_pkg::OFS_REC_W0:    stage_reg[0]   <= i_avs_writedata;
          msrd_pkg::OFS_REC_W1:    stage_reg[1]   <= i_avs_writedata;
          msrd_pkg::OFS_REC_W2:    stage_reg[2]   <= i_avs_writedata;
          msrd_pkg::OFS_REC_W3:    stage_reg[3]   <= i_avs_writedata;
          msrd_pkg::OFS_COND_IDX:  cond_index_reg <= i_avs_writedata[6:0];
          msrd_pkg::OFS_TAG: begin
            host_trst_reg   <= i_avs_writedata[msrd_pkg::TAG_RESET_BIT];
            host_errclr_reg <= i_avs_writedata[msrd_pkg::TAG_ERRCLR_BIT];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Record storage: sequence records through the staging words, condition records straight from the bus
  always_ff @(posedge i_clk) begin
    if (bus_take && i_avs_write && i_avs_address == msrd_pkg::OFS_REC_CMD &&
        i_avs_writedata[msrd_pkg::REC_COMMIT_BIT] &&
        rec_index_reg != 9'h000 && int'(rec_index_reg) <= SEQ_DEPTH) begin
      seq_mem[int'(rec_index_reg) - 1] <= unpack(stage_reg[0], stage_reg[1],
                                                 stage_reg[2], stage_reg[3]);
    end
    if (bus_take && i_avs_write && i_avs_address == msrd_pkg::OFS_COND_DATA &&
        cond_index_reg != 7'h00 && int'(cond_index_reg) <= COND_DEPTH) begin
      cond_mem[int'(cond_index_reg) - 1] <= i_avs_writedata;
    end
  end

  // Sequence executor
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg      <= msrd_pkg::ST_IDLE;
      cur_reg        <= '0;
      seq_reg        <= 9'h001;
      base_seq_reg   <= 9'h001;
      run_first_reg  <= 1'b0;
      dwell_left_reg <= 10'h000;
      tick_reg       <= 32'h0000_0000;
      loop_valid     <= '0;
      o_axis_start   <= 4'h0;
      o_axis_stop    <= 4'h0;
      o_force_fwd    <= 4'h0;
      o_force_rev    <= 4'h0;
      o_helical_z    <= 4'h0;
      o_end_pattern  <= 3'h0;
      o_tag_code     <= 10'h000;
      o_tag_valid    <= 1'b0;
      o_running      <= 1'b0;
      for (int i = 0; i < msrd_pkg::LOOP_DEPTH; i++) begin
        loop_seq[i]  <= 9'h000;
        loop_cond[i] <= 7'h00;
      end
    end else begin
      o_axis_start <= 4'h0;
      o_axis_stop  <= 4'h0;
      if (host_abort_reg && state_reg != msrd_pkg::ST_IDLE) begin
        o_axis_stop <= 4'hF;
        o_running   <= 1'b0;
        o_force_fwd <= 4'h0;
        o_force_rev <= 4'h0;
        o_tag_valid <= 1'b0;
        state_reg   <= msrd_pkg::ST_IDLE;
      end else begin
        case (state_reg)
          msrd_pkg::ST_IDLE: begin
            if (host_start_reg) begin
              seq_reg      <= start_seq_reg;
              base_seq_reg <= start_seq_reg;
              loop_valid   <= '0;
              o_running    <= 1'b1;
              state_reg    <= msrd_pkg::ST_FETCH;
            end
          end
          msrd_pkg::ST_FETCH: begin
            if (seq_reg == 9'h000 || int'(seq_reg) > SEQ_DEPTH) begin
              state_reg <= msrd_pkg::ST_FAULT;
            end else begin
              cur_reg   <= seq_mem[int'(seq_reg) - 1];
              state_reg <= msrd_pkg::ST_CHECK;
            end
          end
          msrd_pkg::ST_CHECK: begin
            if (!rec_ok(cur_reg)) begin
              state_reg <= msrd_pkg::ST_FAULT;
            end else if (cur_reg.cmd[15:8] == msrd_pkg::CMD_MOTION_HI) begin
              state_reg <= msrd_pkg::ST_WSTART;
            end else if (cur_reg.cmd[15]) begin
              state_reg <= msrd_pkg::ST_ADV;
            end else begin
              case (cur_reg.cmd)
                msrd_pkg::CMD_NONE, msrd_pkg::CMD_PSET, msrd_pkg::CMD_PRSET: begin
                  state_reg <= msrd_pkg::ST_ADV;
                end
                msrd_pkg::CMD_JUMP: begin
                  if (cond_met(cur_reg.jcond)) begin
                    seq_reg   <= cur_reg.jdest;
                    state_reg <= msrd_pkg::ST_FETCH;
                  end else begin
                    state_reg <= msrd_pkg::ST_ADV;
                  end
                end
                msrd_pkg::CMD_FOR: begin
                  loop_seq[cur_reg.loopno]   <= seq_reg;
                  loop_cond[cur_reg.loopno]  <= cur_reg.jcond;
                  loop_valid[cur_reg.loopno] <= 1'b1;
                  state_reg                  <= msrd_pkg::ST_ADV;
                end
                msrd_pkg::CMD_NEXT: begin
                  if (!loop_valid[cur_reg.loopno]) begin
                    state_reg <= msrd_pkg::ST_FAULT;
                  end else if (cond_met(loop_cond[cur_reg.loopno])) begin
                    seq_reg   <= loop_seq[cur_reg.loopno] + 9'h001;
                    state_reg <= msrd_pkg::ST_FETCH;
                  end else begin
                    loop_valid[cur_reg.loopno] <= 1'b0;
                    state_reg                  <= msrd_pkg::ST_ADV;
                  end
                end
                msrd_pkg::CMD_END: begin
                  seq_reg   <= base_seq_reg;
                  o_running <= 1'b0;
                  state_reg <= msrd_pkg::ST_IDLE;
                end
                default: state_reg <= msrd_pkg::ST_FAULT;
              endcase
            end
          end
          msrd_pkg::ST_WSTART: begin
            if (cond_met(cur_reg.scond)) begin
              o_axis_start  <= cur_reg.axes;
              o_helical_z   <= cur_reg.zaxis;
              o_end_pattern <= cur_reg.endpat;
              if (cur_reg.outsig != 16'h0000) begin
                if (cur_reg.outsig[7:0] == msrd_pkg::OUT_FWD) begin
                  o_force_fwd[cur_reg.outsig[9:8] - 2'h1] <= 1'b1;
                end else begin
                  o_force_rev[cur_reg.outsig[9:8] - 2'h1] <= 1'b1;
                end
              end
              run_first_reg <= 1'b1;
              state_reg     <= msrd_pkg::ST_RUN;
            end
          end
          msrd_pkg::ST_RUN: begin
            run_first_reg <= 1'b0;
            if (cur_reg.kcond != 7'h00 && cond_met(cur_reg.kcond)) begin
              o_axis_stop <= cur_reg.axes;
              state_reg   <= msrd_pkg::ST_INPOS;
            end else if (cur_reg.endpat > msrd_pkg::END_AUTO) begin
              state_reg <= msrd_pkg::ST_TAG;
            end else if (!run_first_reg && (i_axis_busy & cur_reg.axes) == 4'h0) begin
              state_reg <= msrd_pkg::ST_INPOS;
            end
          end
          msrd_pkg::ST_INPOS: begin
            if (!cur_reg.mon || (i_axis_inpos & cur_reg.axes) == cur_reg.axes) begin
              if (cur_reg.endpat <= msrd_pkg::END_AUTO && cur_reg.dwell != 10'h000) begin
                dwell_left_reg <= cur_reg.dwell;
                tick_reg       <= 32'h0000_0000;
                state_reg      <= msrd_pkg::ST_DWELL;
              end else begin
                state_reg <= msrd_pkg::ST_TAG;
              end
            end
          end
          msrd_pkg::ST_DWELL: begin
            if (tick_reg == 32'(TICK_CYCLES - 1)) begin
              tick_reg       <= 32'h0000_0000;
              dwell_left_reg <= dwell_left_reg - 10'h001;
              if (dwell_left_reg == 10'h001) begin
                state_reg <= msrd_pkg::ST_TAG;
              end
            end else begin
              tick_reg <= tick_reg + 32'h0000_0001;
            end
          end
          msrd_pkg::ST_TAG: begin
            if (cur_reg.tag == 10'h000) begin
              state_reg <= msrd_pkg::ST_ADV;
            end else begin
              o_tag_code  <= cur_reg.tag;
              o_tag_valid <= 1'b1;
              if (cur_reg.tag >= msrd_pkg::TAG_NOWAIT) begin
                state_reg <= msrd_pkg::ST_ADV;
              end else begin
                state_reg <= msrd_pkg::ST_TWAIT;
              end
            end
          end
          msrd_pkg::ST_TWAIT: begin
            if (host_trst_reg) begin
              o_tag_valid <= 1'b0;
              state_reg   <= msrd_pkg::ST_ADV;
            end
          end
          msrd_pkg::ST_ADV: begin
            o_force_fwd <= 4'h0;
            o_force_rev <= 4'h0;
            seq_reg     <= seq_reg + 9'h001;
            state_reg   <= msrd_pkg::ST_FETCH;
          end
          msrd_pkg::ST_FAULT: begin
            o_running   <= 1'b0;
            o_force_fwd <= 4'h0;
            o_force_rev <= 4'h0;
            state_reg   <= msrd_pkg::ST_IDLE;
          end
          default: state_reg <= msrd_pkg::ST_IDLE;
        endcase
      end
    end
  end

  // Error flag; a new fault wins over a host clear
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_error <= 1'b0;
    end else if (state_reg == msrd_pkg::ST_FAULT) begin
      o_error <= 1'b1;
    end else if (host_errclr_reg) begin
      o_error <= 1'b0;
    end
  end

endmodule // msrd_top

// [msrd_chk.sv]
// Port-level checker of the motion sequence record decoder
module msrd_chk (
  // Clock and reset
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  // Register bus
  input wire logic [3:0]  i_avs_address,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic        o_avs_waitrequest,
  // Drives and status
  input wire logic [3:0]  o_axis_start,
  input wire logic [3:0]  o_axis_stop,
  input wire logic [3:0]  o_force_fwd,
  input wire logic [3:0]  o_force_rev,
  input wire logic [3:0]  o_helical_z,
  input wire logic [2:0]  o_end_pattern,
  input wire logic [9:0]  o_tag_code,
  input wire logic        o_tag_valid,
  input wire logic        o_running,
  input wire logic        o_error
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  AST_BUS_ACK: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
    |=> !o_avs_waitrequest) else $error("bus answer late");
  AST_BUS_ONE: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("wait low too long");
  AST_START_PULSE: assert property (o_axis_start != 4'h0 |-> o_running ##1
    o_axis_start == 4'h0) else $error("bad start pulse");
  AST_STOP_PULSE: assert property (o_axis_stop != 4'h0 |=> o_axis_stop == 4'h0)
    else $error("stop pulse too long");
  AST_Z_ONEHOT: assert property ($onehot0(o_helical_z))
    else $error("z mask not one-hot");
  AST_END_RANGE: assert property (o_end_pattern <= 3'h4)
    else $error("end pattern out of range");
  AST_FORCE_ONE: assert property ($onehot0({o_force_fwd, o_force_rev}))
    else $error("more than one forced output");
  AST_TAG_RANGE: assert property (o_tag_valid |-> o_tag_code inside {[10'h1:10'h3E7]})
    else $error("tag shown out of range");
  AST_TAG_HOLD: assert property (o_tag_valid && o_tag_code < 10'h1F4 &&
    !($past(i_avs_write) && $past(i_avs_address) inside {4'h0, 4'hA})
    |=> o_tag_valid && o_running) else $error("wait tag dropped");
  AST_ERR_STOP: assert property ($rose(o_error) |=> !o_running)
    else $error("ran on after error");
  AST_ERR_HOLD: assert property (o_error &&
    !($past(i_avs_write) && $past(i_avs_address) == 4'hA) |=> o_error)
    else $error("error lost");
endmodule // msrd_chk
bind msrd_top msrd_chk u_chk (.*);

// [msrd_axis_model.sv]
// Axis drive model: busy for four cycles after start, in-position two cycles after busy drops
module msrd_axis_model #(parameter int DLY = 6) (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // Drive side
  input  wire logic [3:0] i_start,
  output logic      [3:0] o_busy,
  output logic      [3:0] o_inpos
);
  logic [3:0] msk_reg;
  int         cnt_reg;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_reg <= 0;
      msk_reg <= 4'h0;
    end else if (i_start != 4'h0) begin
      cnt_reg <= DLY;
      msk_reg <= i_start;
    end else if (cnt_reg != 0) cnt_reg <= cnt_reg - 1;
  end
  assign o_busy  = (cnt_reg > 2) ? msk_reg : 4'h0;
  assign o_inpos = (cnt_reg == 0) ? 4'hF : ~msk_reg;
endmodule // msrd_axis_model

// [msrd_top_tb.sv]
// Self-checking testbench of the motion sequence record decoder
module msrd_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clk, i_rst_n, i_avs_read, i_avs_write, o_avs_waitrequest;
  logic        o_tag_valid, o_running, o_error;
  logic [3:0]  i_avs_address, i_axis_busy, i_axis_inpos, o_axis_start, o_axis_stop;
  logic [3:0]  o_force_fwd, o_force_rev, o_helical_z;
  logic [2:0]  o_end_pattern;
  logic [9:0]  o_tag_code;
  logic [15:0] i_sense;
  logic [31:0] i_avs_writedata, o_avs_readdata, q;
  int          fail_count, n_tests, nst;
  msrd_top #(.TICK_CYCLES(4)) dut (.*);
  msrd_axis_model u_axes (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_start(o_axis_start),
    .o_busy(i_axis_busy), .o_inpos(i_axis_inpos));
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) if (o_axis_start != 4'h0) nst <= nst + 1;
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic to(input logic ok);
    if (ok !== 1'b1) begin
      fail_count++;
      $display("[FAIL] %0t wait ran out", $time);
      stop_test();
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    @(posedge i_clk);
    i_avs_address   <= a;
    i_avs_writedata <= d;
    i_avs_write     <= w;
    i_avs_read      <= !w;
    for (k = 0; k < 20; k++) begin
      @(posedge i_clk);
      if (o_avs_waitrequest === 1'b0) break;
    end
    q = o_avs_readdata;
    to(k < 20);
    i_avs_write <= 1'b0;
    i_avs_read  <= 1'b0;
  endtask
  function automatic logic [31:0] w2(input logic [2:0] e, input logic [9:0] dw,
    input logic m, input logic [9:0] t, input logic [3:0] ax, input logic [3:0] z);
    return {z, ax, t, m, dw, e};
  endfunction
  task automatic rec(input logic [8:0] n, input logic [31:0] a, input logic [31:0] b,
    input logic [31:0] c, input logic [5:0] l);
    bus(1'b1, 4'h2, {23'h0, n});
    bus(1'b1, 4'h3, a);
    bus(1'b1, 4'h4, b);
    bus(1'b1, 4'h5, c);
    bus(1'b1, 4'h6, {26'h0, l});
    bus(1'b1, 4'h7, 32'h1);
  endtask
  task automatic idle();
    int k;
    repeat (4) @(posedge i_clk);
    for (k = 0; k < 500 && o_running !== 1'b0; k++) @(posedge i_clk);
    to(k < 500);
  endtask
  task automatic t_regs();
    bus(1'b0, 4'h0, 32'h0);
    chk(q, 32'h0001_0000);
    bus(1'b0, 4'hF, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, 4'h2, 32'h1F4);
    bus(1'b0, 4'h2, 32'h0);
    chk(q, 32'h1F4);
  endtask
  task automatic t_motion();
    int k;
    rec(9'h1, 32'h800, 32'h203, w2(3'h0, 10'h2, 1'b1, 10'h1F4, 4'h5, 4'h2), 6'h0);
    rec(9'h2, 32'h4F, 32'h0, 32'h0, 6'h0);
    bus(1'b1, 4'h0, 32'h0001_0001);
    for (k = 0; k < 50 && o_axis_start == 4'h0; k++) @(posedge i_clk);
    to(k < 50);
    chk(32'(o_axis_start), 32'h5);
    chk(32'(o_force_fwd), 32'h2);
    chk(32'(o_helical_z), 32'h2);
    chk(32'(o_end_pattern), 32'h0);
    idle();
    chk({o_tag_valid, o_tag_code}, 32'h5F4);
  endtask
  task automatic t_jump(input logic [6:0] c, input logic [15:0] s, input int e);
    int k;
    int n;
    i_sense <= s;
    bus(1'b1, 4'h8, 32'h1);
    bus(1'b1, 4'h9, 32'h1234_FFFF);
    rec(9'h1, {9'h3, c, 16'h1}, 32'h0, 32'h0, 6'h0);
    rec(9'h2, 32'h800, 32'h0, w2(3'h2, 10'h0, 1'b0, 10'h0, 4'h1, 4'h0), 6'h0);
    rec(9'h3, 32'h800, 32'h0, w2(3'h2, 10'h0, 1'b0, 10'h5, 4'h8, 4'h0), 6'h0);
    rec(9'h4, 32'h4F, 32'h0, 32'h0, 6'h0);
    n = nst;
    bus(1'b1, 4'h0, 32'h0001_0001);
    for (k = 0; k < 200 && !(o_tag_valid && o_tag_code == 10'h5); k++) @(posedge i_clk);
    to(k < 200);
    repeat (6) @(posedge i_clk);
    chk(32'(o_running), 32'h1);
    bus(1'b1, 4'hA, 32'h1);
    idle();
    chk(nst - n, e);
    bus(1'b0, 4'h1, 32'h0);
    chk(32'(q[12:4]), 32'h1);
  endtask
  task automatic t_loop();
    bus(1'b1, 4'h8, 32'h2);
    bus(1'b1, 4'h9, 32'h0001_FFFF);
    rec(9'h1, {9'h0, 7'h2, 16'h2}, 32'h0, 32'h0, 6'h7);
    rec(9'h2, 32'h800, 32'h0, w2(3'h2, 10'h0, 1'b0, 10'h0, 4'h2, 4'h0), 6'h0);
    rec(9'h3, 32'h3, 32'h0, 32'h0, 6'h8);
    bus(1'b1, 4'h0, 32'h0001_0001);
    idle();
    chk(32'(o_error), 32'h1);
    bus(1'b1, 4'hA, 32'h2);
    rec(9'h3, 32'h3, 32'h0, 32'h0, 6'h7);
    bus(1'b1, 4'h0, 32'h0001_0001);
    idle();
    chk(32'(o_error), 32'h0);
  endtask
  task automatic t_skip();
    int k;
    int n;
    i_sense <= 16'h0;
    bus(1'b1, 4'h8, 32'h2);
    bus(1'b1, 4'h9, 32'h0004_0004);
    rec(9'h1, 32'h800, 32'h0082_0404, w2(3'h0, 10'h0, 1'b0, 10'h0, 4'h1, 4'h0), 6'h0);
    rec(9'h2, 32'h4F, 32'h0, 32'h0, 6'h0);
    n = nst;
    bus(1'b1, 4'h0, 32'h0001_0001);
    repeat (20) @(posedge i_clk);
    chk(nst - n, 0);
    i_sense <= 16'h1234;
    for (k = 0; k < 50 && o_axis_stop == 4'h0; k++) @(posedge i_clk);
    to(k < 50);
    chk(32'(o_axis_stop), 32'h1);
    chk(32'(o_force_rev), 32'h8);
    chk(nst - n, 1);
    idle();
    i_sense <= 16'h0;
  endtask
  task automatic t_bad();
    logic [31:0] bad [4];
    bad = '{w2(3'h5, 10'h0, 1'b0, 10'h0, 4'h1, 4'h0), w2(3'h0, 10'h0, 1'b0, 10'h0, 4'h1, 4'h3),
      w2(3'h0, 10'h0, 1'b0, 10'h3E8, 4'h1, 4'h0), w2(3'h0, 10'h3E9, 1'b0, 10'h0, 4'h1, 4'h0)};
    foreach (bad[i]) begin
      rec(9'h1, 32'h800, 32'h0, bad[i], 6'h0);
      bus(1'b1, 4'h0, 32'h0001_0001);
      idle();
      chk(32'(o_error), 32'h1);
      bus(1'b1, 4'hA, 32'h2);
      idle();
      chk(32'(o_error), 32'h0);
    end
  endtask
  initial begin
    {i_rst_n, i_avs_read, i_avs_write, i_avs_address, i_avs_writedata, i_sense} = '0;
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'b1;
    t_regs();
    t_motion();
    t_jump(7'h0, 16'h0, 1);
    t_jump(7'h1, 16'h1234, 1);
    t_jump(7'h1, 16'h0, 2);
    t_loop();
    t_skip();
    t_bad();
    stop_test();
  end
endmodule // msrd_top_tb
